/* File: logic/asf_flag_store.sv */
// Five-bit flag store with separate hardware and software write paths
`timescale 1ns/10ps
`include "asf_regs.svh"
module asf_flag_store (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [4:0]        hw_mask,
	input  asf_pkg::asf_flags_t    hw_flags,
	input  wire logic              sw_we,
	input  asf_pkg::asf_flags_t    sw_flags,
	output asf_pkg::asf_flags_t    flags_q
);
	import asf_pkg::*;

	typedef struct packed {
		asf_flags_t flags;
	} asf_store_t;

	asf_store_t st_q;
	asf_store_t st_d;

	// Hardware updates win over software writes per bit
	always_comb begin
		logic [4:0] cur;
		logic [4:0] nxt;
		cur = st_q.flags;
		nxt = cur;
		if (sw_we) begin
			nxt = sw_flags;
		end
		nxt = (nxt & ~hw_mask) | (hw_flags & hw_mask);
		st_d.flags = nxt;
	end

	// Flags are unknown at power-up; reset only clears them for determinism
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign flags_q = st_q.flags;
endmodule

/* File: logic/asf_pkg.sv */
// Types shared by the ALU flag block
package asf_pkg;
	typedef logic [4:0] asf_op_t;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [2:0] bitsel;
	} asf_operands_t;

	typedef struct packed {
		logic neg;
		logic ovf;
		logic zero;
		logic dcy;
		logic cy;
	} asf_flags_t;
endpackage

/* File: logic/asf_regs.svh */
// Register offsets, field positions and op codes of the ALU flag block
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH

`define ASF_FLAGS_ADDR   12'hFD8
`define ASF_BIT_NEG      4
`define ASF_BIT_OVF      3
`define ASF_BIT_ZERO     2
`define ASF_BIT_DCY      1
`define ASF_BIT_CY       0
`define ASF_IMPL_MASK    8'h1F
`define ASF_MSB          7
`define ASF_NIB_MSB      3
`define ASF_NIB_HI       4
`define ASF_NIB_W        5
`define ASF_MASK_ARITH   5'h1F
`define ASF_MASK_LOGIC   5'h14
`define ASF_MASK_CLEAR   5'h04
`define ASF_MASK_ROT     5'h17

`define ASF_OP_NONE      5'h00
`define ASF_OP_ADD_W_TO_FILE     5'h01
`define ASF_OP_ADD_LITERAL     5'h02
`define ASF_OP_SUBTRACT_W_FROM_LITERAL     5'h03
`define ASF_OP_SUBTRACT_W_FROM_FILE     5'h04
`define ASF_OP_AND       5'h05
`define ASF_OP_IOR       5'h06
`define ASF_OP_XOR       5'h07
`define ASF_OP_CLEAR_FILE_OP      5'h08
`define ASF_OP_RRF       5'h09
`define ASF_OP_RLF       5'h0A
`define ASF_OP_BCF       5'h0B
`define ASF_OP_BSF       5'h0C
`define ASF_OP_SWAP_NIBBLES_OP     5'h0D
`define ASF_OP_MOVE_FILE_TO_FILE     5'h0E
`define ASF_OP_MOVE_W_TO_FILE     5'h0F
`define ASF_OP_MOVF      5'h10

`endif

/* File: logic/asf_status_alu.sv */
// ALU datapath with status flag register
`timescale 1ns/10ps
`include "asf_regs.svh"
// Operation
// - Flag register reads and writes like any data operand at its address.
// - Flag-affecting op targeting flag register: result write to flags blocked.
// - Clear targeting flag register sets zero only, other flags kept.
// - Bit clear, bit set, swap and moves other than MOVF leave all five flags alone unless aimed at the flag register.
// - Bits 7 to 5 read zero, writes ignored.
// - Negative flag follows result bit 7.
// - Overflow flag set when signed result sign is wrong.
// - Zero flag set when result is zero.
// - Digit carry from low nibble for the four add/sub ops.
// - Carry from bit 7 for the four add/sub ops.
// - Subtract adds two's complement; carries mean no borrow.
// - Rotates load digit carry from bit 3 or bit 4 of source.
// - Rotates load carry from bit 0 or bit 7 of source.
module asf_status_alu (
	input  wire logic           clk,
	input  wire logic           nrst,
	input  wire logic           exec,
	input  asf_pkg::asf_op_t    op,
	input  asf_pkg::asf_operands_t opnd,
	input  wire logic [11:0]    dest_addr,
	input  wire logic           dest_file,
	input  wire logic [11:0]    addr,
	input  wire logic [7:0]     wdata,
	input  wire logic           wr,
	input  wire logic           rd,
	output logic [7:0]          rdata,
	output logic [7:0]          result_q,
	output logic                result_vld_q,
	output asf_pkg::asf_flags_t flags_out_q
);
	import asf_pkg::*;

	// ---------------------------------------------------------------
	// Arithmetic helpers
	// ---------------------------------------------------------------
	function automatic logic [8:0] add9(input logic [7:0] x,
		input logic [7:0] y, input logic ci);
		add9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
	endfunction

	function automatic logic [4:0] add5(input logic [3:0] x,
		input logic [3:0] y, input logic ci);
		add5 = {1'b0, x} + {1'b0, y} + {4'h0, ci};
	endfunction

	function automatic logic is_addsub(input asf_op_t o);
		is_addsub = (o == `ASF_OP_ADD_W_TO_FILE) || (o == `ASF_OP_ADD_LITERAL) ||
			(o == `ASF_OP_SUBTRACT_W_FROM_LITERAL) || (o == `ASF_OP_SUBTRACT_W_FROM_FILE);
	endfunction

	function automatic logic is_sub(input asf_op_t o);
		is_sub = (o == `ASF_OP_SUBTRACT_W_FROM_LITERAL) || (o == `ASF_OP_SUBTRACT_W_FROM_FILE);
	endfunction

	// Logic ops touch only zero and negative
	function automatic logic is_logic(input asf_op_t o);
		is_logic = (o == `ASF_OP_AND) || (o == `ASF_OP_IOR) ||
			(o == `ASF_OP_XOR) || (o == `ASF_OP_MOVF);
	endfunction

	typedef struct packed {
		logic [7:0] result;
		logic       result_vld;
		logic [7:0] rdata;
		asf_flags_t flags_out;
	} asf_state_t;

	asf_state_t s_q;
	asf_state_t s_d;
	asf_flags_t flags_q;
	logic [4:0] hw_mask;
	asf_flags_t hw_flags;
	logic       sw_we;
	asf_flags_t sw_flags;
	logic [7:0] res;
	logic [7:0] xa;
	logic [7:0] yb;
	logic [8:0] sum;
	logic [4:0] nib;
	logic       to_flags;

	// ---------------------------------------------------------------
	// Result and flag computation
	// ---------------------------------------------------------------
	always_comb begin
		xa = opnd.a;
		yb = opnd.b;
		res = opnd.a;
		hw_mask = 5'h00;
		hw_flags = '0;
		// Subtract by adding the inverted operand plus one
		if (is_sub(op)) begin
			yb = ~opnd.b;
		end
		sum = add9(xa, yb, is_sub(op));
		nib = add5(xa[`ASF_NIB_MSB:0], yb[`ASF_NIB_MSB:0],
			is_sub(op));
		if (exec) begin
			if (is_addsub(op)) begin
				res = sum[7:0];
				hw_mask = `ASF_MASK_ARITH;
				hw_flags.cy = sum[8];
				hw_flags.dcy = nib[`ASF_NIB_HI];
				hw_flags.ovf = (xa[`ASF_MSB] == yb[`ASF_MSB]) &&
					(res[`ASF_MSB] != xa[`ASF_MSB]);
			end else if (is_logic(op)) begin
				res = (op == `ASF_OP_AND) ? (xa & opnd.b) :
					(op == `ASF_OP_IOR) ? (xa | opnd.b) :
					(op == `ASF_OP_XOR) ? (xa ^ opnd.b) : xa;
				hw_mask = `ASF_MASK_LOGIC;
			end else if (op == `ASF_OP_CLEAR_FILE_OP) begin
				res = 8'h00;
				hw_mask = `ASF_MASK_CLEAR;
			end else if (op == `ASF_OP_RRF) begin
				res = {xa[0], xa[`ASF_MSB:1]};
				hw_mask = `ASF_MASK_ROT;
				hw_flags.cy = xa[0];
				hw_flags.dcy = xa[`ASF_NIB_HI];
			end else if (op == `ASF_OP_RLF) begin
				res = {xa[6:0], xa[`ASF_MSB]};
				hw_mask = `ASF_MASK_ROT;
				hw_flags.cy = xa[`ASF_MSB];
				hw_flags.dcy = xa[`ASF_NIB_MSB];
			end else if (op == `ASF_OP_BCF) begin
				res = xa & ~(8'h01 << opnd.bitsel);
			end else if (op == `ASF_OP_BSF) begin
				res = xa | (8'h01 << opnd.bitsel);
			end else if (op == `ASF_OP_SWAP_NIBBLES_OP) begin
				res = {xa[3:0], xa[7:4]};
			end
			hw_flags.neg = res[`ASF_MSB];
			hw_flags.zero = (res == 8'h00);
		end
	end

	// ---------------------------------------------------------------
	// Flag register write paths
	// ---------------------------------------------------------------
	always_comb begin
		to_flags = exec && dest_file && (dest_addr == `ASF_FLAGS_ADDR);
		sw_we = 1'b0;
		sw_flags = flags_q;
		if (wr && addr == `ASF_FLAGS_ADDR) begin
			sw_we = 1'b1;
			sw_flags = wdata[4:0];
		end else if (to_flags && hw_mask == '0) begin
			// An op that affects no flag, aimed here, writes its result's low five bits to the flags
			sw_we = 1'b1;
			sw_flags = res[4:0];
		end
	end

	asf_flag_store u_store (
		.clk      (clk),
		.nrst     (nrst),
		.hw_mask  (hw_mask),
		.hw_flags (hw_flags),
		.sw_we    (sw_we),
		.sw_flags (sw_flags),
		.flags_q  (flags_q)
	);

	// ---------------------------------------------------------------
	// Output registers
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.result = exec ? res : s_q.result;
		s_d.result_vld = exec;
		s_d.rdata = 8'h00;
		if (rd && addr == `ASF_FLAGS_ADDR) begin
			s_d.rdata = {3'b000, flags_q} & `ASF_IMPL_MASK;
		end
		s_d.flags_out = flags_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign result_q = s_q.result;
	assign result_vld_q = s_q.result_vld;
	assign flags_out_q = s_q.flags_out;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Bus side: unimplemented bits and plain software writes
	upper_zero_a: assert property (
		rd |=> rdata[7:5] == 3'b000)
		else $error("upper flag bits not zero");

	sw_write_a: assert property (
		wr && addr == `ASF_FLAGS_ADDR && !exec |=>
		flags_q == $past(wdata[4:0]))
		else $error("flag write lost");

	// ---------------------------------------------------------------
	// Arithmetic flags
	// ---------------------------------------------------------------
	zero_flag_a: assert property (
		exec && is_addsub(op) |=>
		flags_q.zero == (result_q == 8'h00))
		else $error("zero flag wrong");

	neg_flag_a: assert property (
		exec && is_addsub(op) |=> flags_q.neg == result_q[7])
		else $error("negative flag wrong");

	ovf_add_a: assert property (
		exec && (op == `ASF_OP_ADD_W_TO_FILE || op == `ASF_OP_ADD_LITERAL) |=>
		flags_q.ovf == (($past(opnd.a[7]) == $past(opnd.b[7])) &&
		(result_q[7] != $past(opnd.a[7]))))
		else $error("overflow flag wrong");

	dcy_add_a: assert property (
		exec && op == `ASF_OP_ADD_LITERAL |=>
		flags_q.dcy ==
		($past(opnd.a[3:0]) + $past(opnd.b[3:0]) > 5'd15))
		else $error("digit carry wrong");

	carry_add_a: assert property (
		exec && op == `ASF_OP_ADD_W_TO_FILE |=>
		flags_q.cy == ($past(opnd.a) + $past(opnd.b) > 9'd255))
		else $error("carry wrong");

	borrow_sub_a: assert property (
		exec && op == `ASF_OP_SUBTRACT_W_FROM_FILE |=>
		flags_q.cy == ($past(opnd.a) >= $past(opnd.b)))
		else $error("borrow polarity wrong");

	dborrow_sub_a: assert property (
		exec && op == `ASF_OP_SUBTRACT_W_FROM_LITERAL |=>
		flags_q.dcy ==
		($past(opnd.a[3:0]) >= $past(opnd.b[3:0])))
		else $error("digit borrow polarity wrong");

	// ---------------------------------------------------------------
	// Logic and rotate flags
	// ---------------------------------------------------------------
	logic_flag_a: assert property (
		exec && is_logic(op) |=>
		flags_q.zero == (result_q == 8'h00) &&
		flags_q.neg == result_q[7])
		else $error("logic op flags wrong");

	rot_carry_a: assert property (
		exec && op == `ASF_OP_RLF |=>
		flags_q.cy == $past(opnd.a[7]) &&
		flags_q.dcy == $past(opnd.a[3]))
		else $error("rotate carry wrong");

	rot_right_a: assert property (
		exec && op == `ASF_OP_RRF |=>
		flags_q.dcy == $past(opnd.a[4]) &&
		flags_q.cy == $past(opnd.a[0]))
		else $error("rotate right flags wrong");

	// ---------------------------------------------------------------
	// Instructions aimed at the flag register, and swap and bit ops aimed elsewhere
	// ---------------------------------------------------------------
	// Bits the op does not own must survive its result
	block_write_a: assert property (
		exec && is_logic(op) && to_flags && !wr |=>
		flags_q.ovf == $past(flags_q.ovf) &&
		flags_q.dcy == $past(flags_q.dcy) &&
		flags_q.cy == $past(flags_q.cy))
		else $error("result reached blocked flag bits");

	clear_flags_a: assert property (
		exec && op == `ASF_OP_CLEAR_FILE_OP && to_flags && !wr |=>
		flags_q == {$past(flags_q.neg), $past(flags_q.ovf), 1'b1,
		$past(flags_q.dcy), $past(flags_q.cy)})
		else $error("clear on flags wrong");

	keep_flags_a: assert property (
		exec && op == `ASF_OP_SWAP_NIBBLES_OP && !wr && !to_flags |=>
		$stable(flags_q))
		else $error("swap changed flags");

	keep_bits_a: assert property (
		exec && (op == `ASF_OP_BCF || op == `ASF_OP_BSF) && !wr &&
		!to_flags |=> $stable(flags_q))
		else $error("bit op changed flags");

	// ---------------------------------------------------------------
	// Output timing
	// ---------------------------------------------------------------
	vld_pulse_a: assert property (
		result_vld_q == $past(exec))
		else $error("result valid not one cycle after exec");

	flags_out_a: assert property (
		flags_out_q == $past(flags_q))
		else $error("flag copy not one cycle behind");

	// Main scenarios
	add_c: cover property (exec && op == `ASF_OP_ADD_W_TO_FILE);
	sub_c: cover property (exec && op == `ASF_OP_SUBTRACT_W_FROM_LITERAL);
	clr_c: cover property (exec && op == `ASF_OP_CLEAR_FILE_OP && to_flags);
	lgc_c: cover property (exec && is_logic(op) && to_flags);
	rd_c: cover property (rd && addr == `ASF_FLAGS_ADDR);
endmodule

/* File: sim/asf_core_model.sv */
// Core-side model that issues instructions into the flag block
`timescale 1ns/10ps
module asf_core_model (
	input  wire logic              clk,
	output logic                   exec,
	output asf_pkg::asf_op_t       op,
	output asf_pkg::asf_operands_t opnd,
	output logic [11:0]            dest_addr,
	output logic                   dest_file
);
	import asf_pkg::*;
	initial begin
		exec = 1'b0;
		op = 5'h00;
		opnd = '0;
		dest_addr = 12'hFD8;
		dest_file = 1'b0;
	end
	// One-cycle exec pulse; dest_file high targets the flag register
	task automatic issue(input asf_op_t o, input logic [7:0] a,
			input logic [7:0] b, input logic [2:0] s, input logic f);
		@(posedge clk);
		exec <= 1'b1;
		op <= o;
		opnd <= {a, b, s};
		dest_file <= f;
		@(posedge clk);
		exec <= 1'b0;
	endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the ALU flag block
`timescale 1ns/10ps
`include "asf_regs.svh"
module tb_top;
	import asf_pkg::*;
	logic                clk;
	logic                nrst;
	logic                exec;
	logic                dest_file;
	logic                wr;
	logic                rd;
	logic                result_vld_q;
	logic [11:0]         dest_addr;
	logic [11:0]         addr;
	logic [7:0]          wdata;
	logic [7:0]          rdata;
	logic [7:0]          result_q;
	logic [7:0]          d;
	logic [4:0]          ef;
	asf_op_t             op;
	asf_operands_t       opnd;
	asf_flags_t          flags_out_q;
	int                  fail_count = 0;
	int                  checks = 0;
	int                  cycles = 0;
	asf_op_t             keep_ops [5] = '{`ASF_OP_BCF, `ASF_OP_BSF,
		`ASF_OP_SWAP_NIBBLES_OP, `ASF_OP_MOVE_FILE_TO_FILE, `ASF_OP_MOVE_W_TO_FILE};

	asf_core_model asf_core_model_inst (.clk(clk), .exec(exec), .op(op),
		.opnd(opnd), .dest_addr(dest_addr), .dest_file(dest_file));
	asf_status_alu asf_status_alu_inst (.clk(clk), .nrst(nrst),
		.exec(exec), .op(op), .opnd(opnd), .dest_addr(dest_addr),
		.dest_file(dest_file), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .result_q(result_q),
		.result_vld_q(result_vld_q), .flags_out_q(flags_out_q));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic flags_chk();
		rd_reg(`ASF_FLAGS_ADDR, d);
		check(d, {3'b000, ef});
		check({3'b000, flags_out_q}, {3'b000, ef});
		check({7'h00, result_vld_q}, 8'h00);
	endtask
	// Subtracts add the inverted operand plus one, so carry means no borrow
	task automatic arith(input asf_op_t o, input logic [7:0] a,
			input logic [7:0] b, input logic f);
		logic       sub;
		logic [7:0] y;
		logic [8:0] s;
		logic [4:0] n;
		sub = (o == `ASF_OP_SUBTRACT_W_FROM_LITERAL) || (o == `ASF_OP_SUBTRACT_W_FROM_FILE);
		y = sub ? ~b : b;
		s = {1'b0, a} + {1'b0, y} + {8'h00, sub};
		n = {1'b0, a[3:0]} + {1'b0, y[3:0]} + {4'h0, sub};
		ef = {s[7], (a[7] == y[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
			n[4], s[8]};
		asf_core_model_inst.issue(o, a, b, 3'h0, f);
		#1 check(result_q, s[7:0]);
		check({7'h00, result_vld_q}, 8'h01);
		flags_chk();
	endtask
	task automatic rot(input asf_op_t o, input logic [7:0] a);
		logic       rr;
		logic [7:0] r;
		rr = (o == `ASF_OP_RRF);
		r = rr ? {a[0], a[7:1]} : {a[6:0], a[7]};
		ef = {r[7], ef[3], r == 8'h00, rr ? a[4] : a[3], rr ? a[0] : a[7]};
		asf_core_model_inst.issue(o, a, 8'h00, 3'h0, 1'b0);
		#1 check(result_q, r);
		flags_chk();
	endtask

	// ----------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 12'h000;
		wdata = 8'h00;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		ef = 5'h00;
		flags_chk();
		wr_reg(`ASF_FLAGS_ADDR, 8'hFF);
		ef = 5'h1F;
		flags_chk();
		rd_reg(12'h123, d);
		check(d, 8'h00);
		arith(`ASF_OP_ADD_W_TO_FILE, 8'h7F, 8'h01, 1'b0);
		arith(`ASF_OP_ADD_LITERAL, 8'hFF, 8'h01, 1'b0);
		arith(`ASF_OP_SUBTRACT_W_FROM_LITERAL, 8'h05, 8'h03, 1'b0);
		arith(`ASF_OP_SUBTRACT_W_FROM_FILE, 8'h03, 8'h05, 1'b0);
		arith(`ASF_OP_SUBTRACT_W_FROM_FILE, 8'h80, 8'h01, 1'b0);
		arith(`ASF_OP_ADD_W_TO_FILE, 8'h0F, 8'h01, 1'b1);
		rot(`ASF_OP_RRF, 8'h11);
		rot(`ASF_OP_RLF, 8'h88);
		asf_core_model_inst.issue(`ASF_OP_XOR, 8'h5A, 8'h5A, 3'h0, 1'b1);
		ef = {1'b0, ef[3], 1'b1, ef[1:0]};
		flags_chk();
		wr_reg(`ASF_FLAGS_ADDR, 8'h0B);
		asf_core_model_inst.issue(`ASF_OP_CLEAR_FILE_OP, 8'h0B, 8'h00, 3'h0, 1'b1);
		ef = 5'h0F;
		flags_chk();
		asf_core_model_inst.issue(`ASF_OP_BSF, 8'h0F, 8'h00, 3'h4, 1'b1);
		ef = 5'h1F;
		flags_chk();
		foreach (keep_ops[i]) begin
			asf_core_model_inst.issue(keep_ops[i], 8'h00, 8'h00, 3'h0, 1'b0);
			flags_chk();
		end
		summarize();
	end
endmodule
